/* core/tmc_pkg.sv */
// Constants shared by the transmit modulator control register block.
// Assumes a single 200 MHz system clock and a three-wire serial link.
package tmc_pkg;
  localparam int FRAME_BITS = 20;
  localparam int DATA_BITS = 16;
  localparam int ADDR_BITS = 4;
  localparam logic [3:0] ADDR_OPCTL = 4'h4;
  localparam logic [3:0] ADDR_REFDIV = 4'h0;
  localparam logic [15:0] OPCTL_RESET = 16'h197d;
  localparam logic [15:0] REFDIV_RESET = 16'h4050;
  localparam int B_PWR = 0;
  localparam int B_HOLD = 1;
  localparam int B_FILT = 3;
  localparam int B_PLL = 4;
  localparam int B_OSC = 5;
  localparam int B_TX = 6;
  localparam int B_DBL = 7;
  localparam int B_MPL = 8;
  localparam int B_PRD = 9;
  localparam int B_OUTB = 10;
  localparam int B_CP_LO = 11;
  localparam int B_AML_LO = 13;
  localparam int B_TRIM = 15;
  localparam int B_LD_LO = 9;
  localparam int B_CPT_LO = 11;
  localparam int SYNC_STAGES = 3;
endpackage

/* core/tmc_sync.sv */
// Three-stage synchroniser with agreement filter for one pin.
// Assumes the pin is asynchronous to CLOCK.
`timescale 1ns/10ps
`default_nettype none
module tmc_sync #(
  parameter logic INIT = 1'b0
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic din,
  output logic dout
);
  logic s1_r;
  logic s2_r;
  logic s3_r;
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      s1_r <= INIT;
      s2_r <= INIT;
      s3_r <= INIT;
      dout <= INIT;
    end else begin
      s1_r <= din;
      s2_r <= s1_r;
      s3_r <= s2_r;
      // A change counts only once the last two stages agree.
      if (s2_r == s3_r) begin
        dout <= s3_r;
      end
    end
  end
endmodule
`default_nettype wire

/* core/tmc_regs.sv */
// Operational and reference-divider control registers of a transmit modulator.
// Assumes a baseband controller drives the three-wire link; its clock is sampled.
`timescale 1ns/10ps
`default_nettype none
module tmc_regs (
  input wire logic CLOCK,
  input wire logic RST_B,
  input wire logic LINK_CLK,
  input wire logic LINK_DATA,
  input wire logic LINK_CS_B,
  input wire logic SHUTDOWN_B,
  input wire logic IDLE_B,
  input wire logic LOCK_IN,
  input wire logic MAIN_DIV_IN,
  input wire logic REF_DIV_IN,
  output logic BASEBAND_FILTER_ENABLE,
  output logic FILTER_BYPASS,
  output logic PLL_ENABLE,
  output logic OSCILLATOR_ENABLE,
  output logic TX_CHAIN_ENABLE,
  output logic REF_DOUBLER_ENABLE,
  output logic MAX_POWER_LEVEL,
  output logic PREDRIVER_BIAS_SELECT,
  output logic OUTPUT_BIAS_SELECT,
  output logic [1:0] CHARGE_PUMP_CURRENT_SELECT,
  output logic [1:0] OFFSET_CORRECTOR_CURRENT,
  output logic OFFSET_TRIM_MODE,
  output logic [8:0] REFERENCE_RATIO_BITS,
  output logic [2:0] CHARGE_PUMP_TEST_SELECT,
  output logic [1:0] LOCK_PIN_SOURCE_SELECT,
  output logic LOCK_INDICATOR_PIN,
  output logic [15:0] OPERATION_CONTROL,
  output logic [15:0] REFERENCE_DIVIDER_CONTROL
);
  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  logic sclk_s;
  logic sdat_s;
  logic scs_s;
  logic power_down_control_s;
  logic idle_s;
  logic lock_s;
  logic mdiv_s;
  logic rdiv_s;

  tmc_sync #(.INIT(1'b0)) u_sclk (.clk(CLOCK), .rst_b(RST_B), .din(LINK_CLK), .dout(sclk_s));
  tmc_sync #(.INIT(1'b0)) u_sdat (.clk(CLOCK), .rst_b(RST_B), .din(LINK_DATA), .dout(sdat_s));
  tmc_sync #(.INIT(1'b1)) u_scs (.clk(CLOCK), .rst_b(RST_B), .din(LINK_CS_B), .dout(scs_s));
  tmc_sync #(.INIT(1'b0)) u_power_down_control (.clk(CLOCK), .rst_b(RST_B), .din(SHUTDOWN_B), .dout(power_down_control_s));
  tmc_sync #(.INIT(1'b0)) u_idle (.clk(CLOCK), .rst_b(RST_B), .din(IDLE_B), .dout(idle_s));
  tmc_sync #(.INIT(1'b0)) u_lock (.clk(CLOCK), .rst_b(RST_B), .din(LOCK_IN), .dout(lock_s));
  tmc_sync #(.INIT(1'b0)) u_mdiv (.clk(CLOCK), .rst_b(RST_B), .din(MAIN_DIV_IN), .dout(mdiv_s));
  tmc_sync #(.INIT(1'b0)) u_rdiv (.clk(CLOCK), .rst_b(RST_B), .din(REF_DIV_IN), .dout(rdiv_s));

  // ------------------------------------------------------------
  // Serial shifter
  // ------------------------------------------------------------
  logic sclk_d_r;
  logic scs_d_r;
  logic [19:0] shift_r;
  logic [19:0] shift_nxt;
  logic [15:0] opctl_r;
  logic [15:0] opctl_nxt;
  logic [15:0] refdiv_r;
  logic [15:0] refdiv_nxt;
  logic sclk_rise;
  logic cs_rise;
  logic [3:0] frame_addr;
  logic [15:0] frame_data;
  logic hit_opctl;
  logic hit_refdiv;

  assign sclk_rise = sclk_s && !sclk_d_r && !scs_s;
  assign cs_rise = scs_s && !scs_d_r;
  // Data first, address last: the address sits in the low nibble.
  assign shift_nxt = sclk_rise ? {shift_r[18:0], sdat_s} : shift_r;
  assign frame_addr = shift_r[tmc_pkg::ADDR_BITS-1:0];
  assign frame_data = shift_r[tmc_pkg::FRAME_BITS-1:tmc_pkg::ADDR_BITS];
  assign hit_opctl = cs_rise && (frame_addr == tmc_pkg::ADDR_OPCTL);
  assign hit_refdiv = cs_rise && (frame_addr == tmc_pkg::ADDR_REFDIV);
  // Any other address falls through both selects untouched.
  assign opctl_nxt = hit_opctl ? frame_data : opctl_r;
  assign refdiv_nxt = hit_refdiv ? frame_data : refdiv_r;

  always_ff @(posedge CLOCK) begin
    if (!RST_B) begin
      sclk_d_r <= 1'b0;
      scs_d_r <= 1'b1;
      shift_r <= 20'h00000;
    end else begin
      sclk_d_r <= sclk_s;
      scs_d_r <= scs_s;
      shift_r <= shift_nxt;
    end
  end

  // ------------------------------------------------------------
  // Register file
  // ------------------------------------------------------------
  // Shutdown never clears these; only reset or a frame changes them.
  always_ff @(posedge CLOCK) begin
    if (!RST_B) begin
      opctl_r <= tmc_pkg::OPCTL_RESET;
      refdiv_r <= tmc_pkg::REFDIV_RESET;
    end else begin
      opctl_r <= opctl_nxt;
      refdiv_r <= refdiv_nxt;
    end
  end

  // ------------------------------------------------------------
  // Power-mode decode
  // ------------------------------------------------------------
  logic powered;
  logic active;
  logic filt_on;
  logic pll_on;
  logic osc_on;
  logic tx_on;
  logic lock_sel;

  assign powered = power_down_control_s && opctl_r[tmc_pkg::B_PWR];
  assign active = powered && idle_s;
  // In standby the filters stay up only when the hold bit asks for it.
  assign filt_on = powered && opctl_r[tmc_pkg::B_FILT]
    && (idle_s || opctl_r[tmc_pkg::B_HOLD]);
  assign pll_on = powered && opctl_r[tmc_pkg::B_PLL];
  assign osc_on = powered && opctl_r[tmc_pkg::B_OSC];
  assign tx_on = active && opctl_r[tmc_pkg::B_TX];
  assign lock_sel = (refdiv_r[10:9] == 2'b00) ? lock_s :
    (refdiv_r[10:9] == 2'b01) ? mdiv_s :
    (refdiv_r[10:9] == 2'b10) ? rdiv_s : 1'b0;

  // ------------------------------------------------------------
  // Output flops
  // ------------------------------------------------------------
  always_ff @(posedge CLOCK) begin
    if (!RST_B) begin
      BASEBAND_FILTER_ENABLE <= 1'b0;
      FILTER_BYPASS <= 1'b0;
      PLL_ENABLE <= 1'b0;
      OSCILLATOR_ENABLE <= 1'b0;
      TX_CHAIN_ENABLE <= 1'b0;
      REF_DOUBLER_ENABLE <= 1'b0;
      MAX_POWER_LEVEL <= 1'b1;
      PREDRIVER_BIAS_SELECT <= 1'b0;
      OUTPUT_BIAS_SELECT <= 1'b0;
      CHARGE_PUMP_CURRENT_SELECT <= 2'h3;
      OFFSET_CORRECTOR_CURRENT <= 2'h0;
      OFFSET_TRIM_MODE <= 1'b0;
      REFERENCE_RATIO_BITS <= 9'h050;
      CHARGE_PUMP_TEST_SELECT <= 3'h0;
      LOCK_PIN_SOURCE_SELECT <= 2'h0;
      LOCK_INDICATOR_PIN <= 1'b0;
      OPERATION_CONTROL <= tmc_pkg::OPCTL_RESET;
      REFERENCE_DIVIDER_CONTROL <= tmc_pkg::REFDIV_RESET;
    end else begin
      BASEBAND_FILTER_ENABLE <= filt_on;
      FILTER_BYPASS <= !opctl_r[tmc_pkg::B_FILT];
      PLL_ENABLE <= pll_on;
      OSCILLATOR_ENABLE <= osc_on;
      TX_CHAIN_ENABLE <= tx_on;
      REF_DOUBLER_ENABLE <= opctl_r[tmc_pkg::B_DBL];
      MAX_POWER_LEVEL <= opctl_r[tmc_pkg::B_MPL];
      PREDRIVER_BIAS_SELECT <= opctl_r[tmc_pkg::B_PRD];
      OUTPUT_BIAS_SELECT <= opctl_r[tmc_pkg::B_OUTB];
      CHARGE_PUMP_CURRENT_SELECT <= opctl_r[tmc_pkg::B_CP_LO +: 2];
      OFFSET_CORRECTOR_CURRENT <= opctl_r[tmc_pkg::B_AML_LO +: 2];
      OFFSET_TRIM_MODE <= opctl_r[tmc_pkg::B_TRIM] && powered;
      REFERENCE_RATIO_BITS <= refdiv_r[8:0];
      CHARGE_PUMP_TEST_SELECT <= refdiv_r[tmc_pkg::B_CPT_LO +: 3];
      LOCK_PIN_SOURCE_SELECT <= refdiv_r[tmc_pkg::B_LD_LO +: 2];
      LOCK_INDICATOR_PIN <= lock_sel;
      OPERATION_CONTROL <= opctl_r;
      REFERENCE_DIVIDER_CONTROL <= refdiv_r;
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  power_down_control_forces_off_a: assert property (@(posedge CLOCK) disable iff (!RST_B)
    !power_down_control_s |=> !PLL_ENABLE && !OSCILLATOR_ENABLE && !TX_CHAIN_ENABLE)
    else $error("Shutdown pin did not force enables off.");
  soft_power_down_control_off_a: assert property (@(posedge CLOCK) disable iff (!RST_B)
    !opctl_r[0] |=> !BASEBAND_FILTER_ENABLE && !PLL_ENABLE)
    else $error("Power bit low left a block on.");
  standby_tx_off_a: assert property (@(posedge CLOCK) disable iff (!RST_B)
    powered && !idle_s |=> !TX_CHAIN_ENABLE && (PLL_ENABLE == $past(opctl_r[4])))
    else $error("Standby decode wrong.");
  active_follow_a: assert property (@(posedge CLOCK) disable iff (!RST_B)
    active |=> TX_CHAIN_ENABLE == $past(opctl_r[6]))
    else $error("Transmit chain ignores its enable.");
  filter_hold_a: assert property (@(posedge CLOCK) disable iff (!RST_B)
    powered && !idle_s && opctl_r[3] |=> BASEBAND_FILTER_ENABLE == $past(opctl_r[1]))
    else $error("Filter hold in standby wrong.");
  latch_opctl_a: assert property (@(posedge CLOCK) disable iff (!RST_B)
    hit_opctl |=> ##1 OPERATION_CONTROL == $past(frame_data, 2))
    else $error("Control frame not latched.");
  ignore_addr_a: assert property (@(posedge CLOCK) disable iff (!RST_B)
    cs_rise && frame_addr != 4'h4 && frame_addr != 4'h0 |=> $stable(opctl_r) && $stable(refdiv_r))
    else $error("Unknown address changed a register.");
  shift_hold_a: assert property (@(posedge CLOCK) disable iff (!RST_B)
    scs_s |=> $stable(shift_r))
    else $error("Shifter moved with chip select high.");
  lock_low_a: assert property (@(posedge CLOCK) disable iff (!RST_B)
    refdiv_r[10:9] == 2'b11 |=> !LOCK_INDICATOR_PIN)
    else $error("Lock pin not low in constant mode.");
endmodule
`default_nettype wire

/* verif/tmc_link_master.sv */
// Behavioural baseband controller that writes frames over the three-wire link.
// Assumes the block samples the link with its own much faster clock.
`timescale 1ns/10ps
`default_nettype none
module tmc_link_master (
  output logic LINK_CLK,
  output logic LINK_DATA,
  output logic LINK_CS_B
);
  initial begin
    LINK_CLK = 1'b0;
    LINK_DATA = 1'b0;
    LINK_CS_B = 1'b1;
  end
  // The link clock stands still low between frames; 48 ns period inside one.
  task automatic send(input logic [15:0] data, input logic [3:0] addr);
    logic [19:0] frame;
    if (addr == tmc_pkg::ADDR_OPCTL) data[2] = 1'b1;
    if (addr == tmc_pkg::ADDR_REFDIV) data[15:14] = 2'b01;
    frame = {data, addr};
    LINK_CS_B = 1'b0;
    for (int i = 19; i >= 0; i--) begin
      LINK_DATA = frame[i];
      #24 LINK_CLK = 1'b1;
      #24 LINK_CLK = 1'b0;
    end
    #24 LINK_CS_B = 1'b1;
    LINK_DATA = ~LINK_DATA;
    // A gap keeps chip select high long enough for the sampler to see it.
    #24;
  endtask
endmodule
`default_nettype wire

/* verif/tb_top.sv */
// Self-checking bench for the modulator control registers.
// Assumes the link master model drives the serial pins.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic clock = 1'b0, rst_b = 1'b0, shutdown_b = 1'b1, idle_b = 1'b1;
  logic lock_in = 1'b0, main_div_in = 1'b0, ref_div_in = 1'b0;
  wire logic link_clk, link_data, link_cs_b;
  logic bfe, byp, pll, osc, txe, dbl, max_power_level, prd, outb, trim, lpin;
  logic [1:0] cpc, occ, lsel;
  logic [8:0] ratio;
  logic [2:0] cpt;
  logic [15:0] opc, rdc, d;
  logic [15:0] op_m = 16'h197d, rd_m = 16'h4050;
  logic [60:0] exp_q[$];
  int num_errors = 0, checked = 0, cycles = 0;
  event look;
  // ----------------------------------------
  // Structure
  // ----------------------------------------
  always #2.5 clock = ~clock;
  tmc_link_master lm (.LINK_CLK(link_clk), .LINK_DATA(link_data), .LINK_CS_B(link_cs_b));
  tmc_regs dut (.CLOCK(clock), .RST_B(rst_b), .LINK_CLK(link_clk), .LINK_DATA(link_data),
    .LINK_CS_B(link_cs_b), .SHUTDOWN_B(shutdown_b), .IDLE_B(idle_b), .LOCK_IN(lock_in),
    .MAIN_DIV_IN(main_div_in), .REF_DIV_IN(ref_div_in), .BASEBAND_FILTER_ENABLE(bfe),
    .FILTER_BYPASS(byp), .PLL_ENABLE(pll), .OSCILLATOR_ENABLE(osc), .TX_CHAIN_ENABLE(txe),
    .REF_DOUBLER_ENABLE(dbl), .MAX_POWER_LEVEL(max_power_level), .PREDRIVER_BIAS_SELECT(prd),
    .OUTPUT_BIAS_SELECT(outb), .CHARGE_PUMP_CURRENT_SELECT(cpc),
    .OFFSET_CORRECTOR_CURRENT(occ), .OFFSET_TRIM_MODE(trim), .REFERENCE_RATIO_BITS(ratio),
    .CHARGE_PUMP_TEST_SELECT(cpt), .LOCK_PIN_SOURCE_SELECT(lsel), .LOCK_INDICATOR_PIN(lpin),
    .OPERATION_CONTROL(opc), .REFERENCE_DIVIDER_CONTROL(rdc));
  // ----------------------------------------
  // Prediction and comparison
  // ----------------------------------------
  function automatic logic [60:0] predict();
    logic pw;
    logic lk;
    pw = shutdown_b & op_m[0];
    lk = rd_m[10] ? (rd_m[9] ? 1'b0 : ref_div_in) : (rd_m[9] ? main_div_in : lock_in);
    return {pw & op_m[3] & (idle_b | op_m[1]), ~op_m[3], pw & op_m[4], pw & op_m[5],
      pw & idle_b & op_m[6], op_m[10:7], op_m[14:11], op_m[15] & pw, rd_m[13:0], lk,
      op_m, rd_m};
  endfunction
  task automatic check(input string name, input logic [60:0] seen, input logic [60:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  always @(look) begin
    logic [60:0] s;
    logic [60:0] e;
    s = {bfe, byp, pll, osc, txe, outb, prd, max_power_level, dbl, occ, cpc, trim, cpt, lsel, ratio, lpin,
      opc, rdc};
    e = exp_q.pop_front();
    check("enables", s[60:56], e[60:56]);
    check("fields", s[55:32], e[55:32]);
    check("registers", s[31:0], e[31:0]);
  end
  // ----------------------------------------
  // Stimulus
  // ----------------------------------------
  task automatic write(input logic [3:0] addr, input logic [15:0] data);
    if (addr == tmc_pkg::ADDR_OPCTL) op_m = data | 16'h0004;
    if (addr == tmc_pkg::ADDR_REFDIV) rd_m = {2'b01, data[13:0]};
    lm.send(data, addr);
  endtask
  task automatic sample(input logic sh, input logic id);
    @(negedge clock);
    shutdown_b = sh;
    idle_b = id;
    {lock_in, main_div_in, ref_div_in} = 3'($urandom());
    repeat (12) @(negedge clock);
    exp_q.push_back(predict());
    ->look;
    @(negedge clock);
  endtask
  task automatic conclude();
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Sized for thirty-four frames; a hang is cut short well beyond that.
  always @(posedge clock) begin
    cycles++;
    if (cycles == 30000) begin
      num_errors++;
      conclude();
    end
  end
  initial begin
    void'($urandom(32'h883d700c));
    repeat (5) @(negedge clock);
    rst_b = 1'b1;
    sample(1'b1, 1'b1);
    for (int i = 0; i < 16; i++) begin
      d = 16'($urandom());
      d[1:0] = i[1:0];
      write(tmc_pkg::ADDR_OPCTL, d);
      sample(i[2], i[3]);
    end
    for (int i = 0; i < 4; i++) begin
      d = 16'($urandom());
      d[10:9] = i[1:0];
      write(tmc_pkg::ADDR_REFDIV, d);
      sample(1'b1, 1'b1);
    end
    for (int a = 1; a < 16; a++) begin
      if (a != 4) write(4'(a), 16'($urandom()));
    end
    sample(1'b1, 1'b0);
    conclude();
  end
endmodule
`default_nettype wire
